// file: hw/tceu_irq.sv
// Sticky interrupt status, mask and level interrupt output
`timescale 1ns/1ns
`default_nettype none
module tceu_irq
    import tceu_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Events and software access
    input wire logic [1:0] set_in,
    input wire logic clr_wr_in,
    input wire logic mask_wr_in,
    input wire logic [1:0] wdata_in,
    // State
    output logic [1:0] status_out,
    output logic [1:0] mask_out,
    output logic irq_out
);

    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] mask_reg;
    logic [1:0] mask_next;
    logic irq_reg;

    // Set wins over a write-one clear
    assign status_next = (status_reg & ~(clr_wr_in ? wdata_in : 2'h0)) | set_in;
    assign mask_next = mask_wr_in ? wdata_in : mask_reg;

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            status_reg <= TCEU_IRQ_RST;
            mask_reg <= TCEU_IRQ_RST;
            irq_reg <= 1'b0;
        end
        else
        begin
            status_reg <= status_next;
            mask_reg <= mask_next;
            irq_reg <= |(status_next & mask_next);
        end
    end

    assign status_out = status_reg;
    assign mask_out = mask_reg;
    assign irq_out = irq_reg;

endmodule : tceu_irq
`default_nettype wire

// file: hw/tceu_pkg.sv
// Constants, register map and carrier types of the timer compare event unit
//
// Contract
// - Compare mode constantly compares 16-bit compare value with selected timer pair.
// - Match drives pin high, low, toggles it, or leaves it, per mode bits.
// - Interrupt flag sets in the same cycle the match action reaches the pin.
// - Mode 1010 sets only the flag; pin is left untouched.
// - Mode 1011 makes an internal special event pulse on match, both units.
// - Special event resets whichever timer pair is that unit's time base.
// - Unit 2 special event also starts conversion, only if converter enabled.
// - Writing zero to unit control forces compare output latch low.
// - PWM mode drives a PWM signal with up to 10-bit duty resolution.
// - Writing zero to unit control releases the pin to the port.
// - PWM uses timer B period and control, compare low byte, unit control.
// - Mode 1001 sets pin high on entry and forces it low on match.
// - Time base per unit chosen by select bits in timer C control.
package tceu_pkg;

    // Register byte offsets
    localparam logic [7:0] TCEU_OFF_U1_LOW = 8'h00;
    localparam logic [7:0] TCEU_OFF_U1_HIGH = 8'h04;
    localparam logic [7:0] TCEU_OFF_U1_CTRL = 8'h08;
    localparam logic [7:0] TCEU_OFF_U2_LOW = 8'h0C;
    localparam logic [7:0] TCEU_OFF_U2_HIGH = 8'h10;
    localparam logic [7:0] TCEU_OFF_U2_CTRL = 8'h14;
    localparam logic [7:0] TCEU_OFF_TC_CTRL = 8'h18;
    localparam logic [7:0] TCEU_OFF_IRQ_STAT = 8'h1C;
    localparam logic [7:0] TCEU_OFF_IRQ_MASK = 8'h20;

    // Reset values
    localparam logic [7:0] TCEU_BYTE_RST = 8'h00;
    localparam logic [1:0] TCEU_IRQ_RST = 2'h0;

    // Field positions
    localparam int TCEU_SEL_HI_BIT = 6;
    localparam int TCEU_SEL_LO_BIT = 3;
    localparam int TCEU_DC_LSB = 4;
    localparam int TCEU_TB_ON_BIT = 2;

    // Unit 2 control bits 7:6 read as zero
    localparam logic [7:0] TCEU_U2_CTRL_MASK = 8'h3F;

    // Mode select codes
    localparam logic [3:0] TCEU_MODE_OFF = 4'h0;
    localparam logic [3:0] TCEU_MODE_TOGGLE = 4'h2;
    localparam logic [3:0] TCEU_MODE_SET_ON_MATCH = 4'h8;
    localparam logic [3:0] TCEU_MODE_CLR_ON_MATCH = 4'h9;
    localparam logic [3:0] TCEU_MODE_SOFT_IRQ = 4'hA;
    localparam logic [3:0] TCEU_MODE_SPECIAL = 4'hB;
    localparam logic [1:0] TCEU_MODE_CMP_GRP = 2'h2;
    localparam logic [1:0] TCEU_MODE_PWM_GRP = 2'h3;

    // Software view of one unit
    typedef struct packed {
        logic [7:0] compare_value_high;
        logic [7:0] compare_value_low;
        logic [7:0] unit_control_reg;
    } tceu_unit_cfg_t;

    // Timer B time base as seen by the PWM logic
    typedef struct packed {
        logic [7:0] count;
        logic [1:0] fine;
        logic [7:0] pwm_period_reg;
        logic [7:0] timer_b_control;
    } tceu_pwm_base_t;

endpackage : tceu_pkg

// file: hw/tceu_top.sv
// Timer compare event unit top: APB registers, two units, triggers, interrupt
`timescale 1ns/1ns
`default_nettype none
module tceu_top
    import tceu_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Timer pairs and timer B time base
    input wire logic [15:0] timer_a_pair_in,
    input wire logic [15:0] timer_c_pair_in,
    input wire logic [7:0] timer_b_count_in,
    input wire logic [1:0] timer_b_fine_in,
    input wire logic [7:0] pwm_period_reg_in,
    input wire logic [7:0] timer_b_control_in,
    // Converter status
    input wire logic adc_enabled_in,
    // Unit pins
    output logic [1:0] unit_output_pin_out,
    output logic [1:0] unit_pin_own_out,
    // Triggers and timer C control
    output logic timer_a_reset_out,
    output logic timer_c_reset_out,
    output logic adc_start_out,
    output logic [7:0] timer_c_control_out,
    // Interrupt
    output logic irq_out
);

    // APB state
    logic pready_reg;
    logic pready_next;
    logic [31:0] prdata_reg;
    logic pslverr_reg;
    logic access;
    logic wr_fire;

    // Registers
    logic [7:0] cmp_low_reg [2];
    logic [7:0] cmp_high_reg [2];
    logic [7:0] ctrl_reg [2];
    logic [7:0] tc_ctrl_reg;

    // Decode
    logic hit_u1_low;
    logic hit_u1_high;
    logic hit_u1_ctrl;
    logic hit_u2_low;
    logic hit_u2_high;
    logic hit_u2_ctrl;
    logic hit_tc;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic [7:0] rd_byte;
    logic [1:0] wr_low;
    logic [1:0] wr_high;
    logic [1:0] wr_ctrl;

    // Units and time bases
    tceu_unit_cfg_t unit_cfg [2];
    tceu_pwm_base_t pwm_base;
    logic [15:0] unit_timer [2];
    logic [1:0] unit_uses_c;
    logic [1:0] unit_pwm;
    logic [1:0] match;
    logic [1:0] special;
    logic period_hit;
    logic period_hit_prev_reg;
    logic period_start;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;

    // Trigger registers
    logic timer_a_reset_reg;
    logic timer_c_reset_reg;
    logic adc_start_reg;

    assign access = psel_in && penable_in;
    assign pready_next = access && !pready_reg;
    assign wr_fire = access && pready_reg && pwrite_in;

    assign hit_u1_low = (paddr_in == TCEU_OFF_U1_LOW);
    assign hit_u1_high = (paddr_in == TCEU_OFF_U1_HIGH);
    assign hit_u1_ctrl = (paddr_in == TCEU_OFF_U1_CTRL);
    assign hit_u2_low = (paddr_in == TCEU_OFF_U2_LOW);
    assign hit_u2_high = (paddr_in == TCEU_OFF_U2_HIGH);
    assign hit_u2_ctrl = (paddr_in == TCEU_OFF_U2_CTRL);
    assign hit_tc = (paddr_in == TCEU_OFF_TC_CTRL);
    assign hit_stat = (paddr_in == TCEU_OFF_IRQ_STAT);
    assign hit_mask = (paddr_in == TCEU_OFF_IRQ_MASK);
    assign mapped = hit_u1_low || hit_u1_high || hit_u1_ctrl || hit_u2_low || hit_u2_high ||
                    hit_u2_ctrl || hit_tc || hit_stat || hit_mask;

    assign rd_byte = hit_u1_low ? cmp_low_reg[0] :
                     hit_u1_high ? cmp_high_reg[0] :
                     hit_u1_ctrl ? ctrl_reg[0] :
                     hit_u2_low ? cmp_low_reg[1] :
                     hit_u2_high ? cmp_high_reg[1] :
                     hit_u2_ctrl ? (ctrl_reg[1] & TCEU_U2_CTRL_MASK) :
                     hit_tc ? tc_ctrl_reg :
                     hit_stat ? {6'h00, irq_status} :
                     hit_mask ? {6'h00, irq_mask} :
                     8'h00;

    assign wr_low = {wr_fire && hit_u2_low, wr_fire && hit_u1_low};
    assign wr_high = {wr_fire && hit_u2_high, wr_fire && hit_u1_high};
    assign wr_ctrl = {wr_fire && hit_u2_ctrl, wr_fire && hit_u1_ctrl};

    // Timer B period end: the count leaves its period value on the next increment
    assign pwm_base = '{count: timer_b_count_in, fine: timer_b_fine_in,
                        pwm_period_reg: pwm_period_reg_in, timer_b_control: timer_b_control_in};
    assign period_hit = timer_b_control_in[TCEU_TB_ON_BIT] && (timer_b_count_in == pwm_period_reg_in);
    assign period_start = period_hit_prev_reg && !period_hit;

    // Time base select held in timer C control
    assign unit_uses_c[0] = tc_ctrl_reg[TCEU_SEL_HI_BIT];
    assign unit_uses_c[1] = tc_ctrl_reg[TCEU_SEL_HI_BIT] || tc_ctrl_reg[TCEU_SEL_LO_BIT];

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg <= pready_next;
            prdata_reg <= pready_next && !pwrite_in ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr_reg <= pready_next && !mapped;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            tc_ctrl_reg <= TCEU_BYTE_RST;
        else if (wr_fire && hit_tc)
            tc_ctrl_reg <= pwdata_in[7:0];
    end

    genvar u;
    generate
        for (u = 0; u < 2; u++)
        begin : g_unit
            assign unit_pwm[u] = (ctrl_reg[u][3:2] == TCEU_MODE_PWM_GRP);
            assign unit_timer[u] = unit_uses_c[u] ? timer_c_pair_in : timer_a_pair_in;
            assign unit_cfg[u] = '{compare_value_high: cmp_high_reg[u], compare_value_low: cmp_low_reg[u],
                                   unit_control_reg: ctrl_reg[u]};

            always_ff @(posedge clk_in)
            begin
                if (!rstn_in)
                begin
                    cmp_low_reg[u] <= TCEU_BYTE_RST;
                    cmp_high_reg[u] <= TCEU_BYTE_RST;
                    ctrl_reg[u] <= TCEU_BYTE_RST;
                end
                else
                begin
                    cmp_low_reg[u] <= wr_low[u] ? pwdata_in[7:0] : cmp_low_reg[u];
                    // High byte is read-only in PWM and takes the duty at period end
                    if (unit_pwm[u] && period_start)
                        cmp_high_reg[u] <= cmp_low_reg[u];
                    else if (wr_high[u] && !unit_pwm[u])
                        cmp_high_reg[u] <= pwdata_in[7:0];
                    ctrl_reg[u] <= wr_ctrl[u] ? pwdata_in[7:0] : ctrl_reg[u];
                end
            end

            tceu_unit u_unit (
                .clk_in(clk_in),
                .rstn_in(rstn_in),
                .cfg_in(unit_cfg[u]),
                .ctrl_wr_in(wr_ctrl[u]),
                .ctrl_wdata_in(pwdata_in[7:0]),
                .timer_in(unit_timer[u]),
                .pwm_in(pwm_base),
                .period_start_in(period_start),
                .match_out(match[u]),
                .special_out(special[u]),
                .pin_out(unit_output_pin_out[u]),
                .pin_own_out(unit_pin_own_out[u])
            );
        end
    endgenerate

    // Special event resets, registered on the same edge as the flag
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            period_hit_prev_reg <= 1'b0;
            timer_a_reset_reg <= 1'b0;
            timer_c_reset_reg <= 1'b0;
            adc_start_reg <= 1'b0;
        end
        else
        begin
            period_hit_prev_reg <= period_hit;
            timer_a_reset_reg <= (special[0] && !unit_uses_c[0]) || (special[1] && !unit_uses_c[1]);
            timer_c_reset_reg <= (special[0] && unit_uses_c[0]) || (special[1] && unit_uses_c[1]);
            adc_start_reg <= special[1] && adc_enabled_in;
        end
    end

    tceu_irq u_irq (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .set_in(match),
        .clr_wr_in(wr_fire && hit_stat),
        .mask_wr_in(wr_fire && hit_mask),
        .wdata_in(pwdata_in[1:0]),
        .status_out(irq_status),
        .mask_out(irq_mask),
        .irq_out(irq_out)
    );

    assign prdata_out = prdata_reg;
    assign pready_out = pready_reg;
    assign pslverr_out = pslverr_reg;
    assign timer_a_reset_out = timer_a_reset_reg;
    assign timer_c_reset_out = timer_c_reset_reg;
    assign adc_start_out = adc_start_reg;
    assign timer_c_control_out = tc_ctrl_reg;

endmodule : tceu_top
`default_nettype wire

// file: hw/tceu_unit.sv
// One compare and PWM unit: match detection, output latch, pin ownership
`timescale 1ns/1ns
`default_nettype none
module tceu_unit
    import tceu_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Configuration and control write
    input wire tceu_unit_cfg_t cfg_in,
    input wire logic ctrl_wr_in,
    input wire logic [7:0] ctrl_wdata_in,
    // Time bases
    input wire logic [15:0] timer_in,
    input wire tceu_pwm_base_t pwm_in,
    input wire logic period_start_in,
    // Results
    output logic match_out,
    output logic special_out,
    output logic pin_out,
    output logic pin_own_out
);

    logic [3:0] mode;
    logic [3:0] mode_after;
    logic is_cmp;
    logic is_pwm;
    logic equal;
    logic hit;
    logic [9:0] duty_new;
    logic [9:0] duty_cur;
    logic [9:0] time_base;
    logic own_next;
    logic equal_prev_reg;
    logic [1:0] dc_latch_reg;
    logic latch_reg;
    logic latch_next;
    logic own_reg;

    assign mode = cfg_in.unit_control_reg[3:0];
    assign is_cmp = (mode == TCEU_MODE_TOGGLE) || (mode[3:2] == TCEU_MODE_CMP_GRP);
    assign is_pwm = (mode[3:2] == TCEU_MODE_PWM_GRP);
    assign equal = ({cfg_in.compare_value_high, cfg_in.compare_value_low} == timer_in);
    assign hit = is_cmp && equal && !equal_prev_reg;
    assign match_out = hit;
    assign special_out = hit && (mode == TCEU_MODE_SPECIAL);
    assign duty_new = {cfg_in.compare_value_low, cfg_in.unit_control_reg[TCEU_DC_LSB+1:TCEU_DC_LSB]};
    assign duty_cur = {cfg_in.compare_value_high, dc_latch_reg};
    assign time_base = {pwm_in.count, pwm_in.fine};
    assign mode_after = ctrl_wr_in ? ctrl_wdata_in[3:0] : mode;
    // Pin belongs to the unit only in pin-driving compare modes and PWM
    assign own_next = (mode_after == TCEU_MODE_TOGGLE) || (mode_after == TCEU_MODE_SET_ON_MATCH) ||
                      (mode_after == TCEU_MODE_CLR_ON_MATCH) || (mode_after[3:2] == TCEU_MODE_PWM_GRP);

    always_comb
    begin
        latch_next = latch_reg;
        if (ctrl_wr_in)
        begin
            if (ctrl_wdata_in == TCEU_BYTE_RST)
                latch_next = 1'b0;
            else if (ctrl_wdata_in[3:0] == TCEU_MODE_SET_ON_MATCH)
                latch_next = 1'b0;
            else if (ctrl_wdata_in[3:0] == TCEU_MODE_CLR_ON_MATCH)
                latch_next = 1'b1;
        end
        else if (hit)
        begin
            if (mode == TCEU_MODE_SET_ON_MATCH)
                latch_next = 1'b1;
            else if (mode == TCEU_MODE_CLR_ON_MATCH)
                latch_next = 1'b0;
            else if (mode == TCEU_MODE_TOGGLE)
                latch_next = ~latch_reg;
        end
        else if (is_pwm && period_start_in)
            latch_next = (duty_new != 10'h000);
        else if (is_pwm && (time_base == duty_cur))
            latch_next = 1'b0;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            equal_prev_reg <= 1'b0;
            dc_latch_reg <= 2'h0;
            latch_reg <= 1'b0;
            own_reg <= 1'b0;
        end
        else
        begin
            equal_prev_reg <= is_cmp && equal;
            dc_latch_reg <= (is_pwm && period_start_in) ? duty_new[1:0] : dc_latch_reg;
            latch_reg <= latch_next;
            own_reg <= own_next;
        end
    end

    assign pin_out = latch_reg;
    assign pin_own_out = own_reg;

endmodule : tceu_unit
`default_nettype wire

// file: verif/tceu_partner.sv
// Behavioural timers and converter beside the compare unit
`timescale 1ns/1ns
`default_nettype none
module tceu_partner (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // Triggers and converter enable
    input wire logic timer_a_reset_in,
    input wire logic timer_c_reset_in,
    input wire logic adc_start_in,
    input wire logic adc_enable_in,
    // Time bases and converter state
    output logic [15:0] timer_a_out,
    output logic [15:0] timer_c_out,
    output logic [9:0] timer_b_out,
    output logic adc_enabled_out,
    output logic [7:0] conv_count_out
);
    // Short wrap keeps match periods small
    localparam logic [15:0] WRAP = 16'h003F;
    // Timer B clears after period value 07 and its last fine step
    localparam logic [9:0] B_TOP = 10'h01F;
    always_ff @(posedge clk_in)
    begin
        timer_a_out <= (!rstn_in || timer_a_reset_in || timer_a_out == WRAP) ? 16'h0000 : timer_a_out + 16'h0001;
        timer_c_out <= (!rstn_in || timer_c_reset_in || timer_c_out == WRAP) ? 16'h0000 : timer_c_out + 16'h0001;
        timer_b_out <= (!rstn_in || timer_b_out == B_TOP) ? 10'h000 : timer_b_out + 10'h001;
        adc_enabled_out <= rstn_in && adc_enable_in;
        if (!rstn_in)
            conv_count_out <= 8'h00;
        else if (adc_start_in && adc_enabled_out)
            conv_count_out <= conv_count_out + 8'h01;
    end
endmodule : tceu_partner
`default_nettype wire

// file: verif/tceu_props.sv
// Port checker for the timer compare event unit
`timescale 1ns/1ns
`default_nettype none
module tceu_props
    import tceu_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rstn_in,
    // APB
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    // Events and pins
    input wire logic adc_enabled_in,
    input wire logic [1:0] unit_output_pin_out,
    input wire logic [1:0] unit_pin_own_out,
    input wire logic timer_a_reset_out,
    input wire logic timer_c_reset_out,
    input wire logic adc_start_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    logic [3:0] mode1_reg;
    wire logic u1_wr = psel_in && penable_in && pready_out && pwrite_in && paddr_in == TCEU_OFF_U1_CTRL;
    // Shadow of unit 1 mode bits
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            mode1_reg <= 4'h0;
        else if (u1_wr)
            mode1_reg <= pwdata_in[3:0];
    end
    AST_READY_WAIT: assert property (psel_in && penable_in && !$past(penable_in) |-> !pready_out ##1 pready_out)
        else $error("pready not in second access cycle");
    AST_READY_ONE: assert property (pready_out |=> !pready_out)
        else $error("pready longer than one cycle");
    AST_ERR_RDY: assert property (pslverr_out |-> pready_out)
        else $error("pslverr without pready");
    AST_RDATA_HI: assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_TA_PULSE: assert property (timer_a_reset_out |=> !timer_a_reset_out)
        else $error("timer A reset pulse too long");
    AST_TC_PULSE: assert property (timer_c_reset_out |=> !timer_c_reset_out)
        else $error("timer C reset pulse too long");
    AST_ADC_TRIG: assert property (adc_start_out |-> (timer_a_reset_out || timer_c_reset_out) && $past(adc_enabled_in))
        else $error("conversion start without trigger or enable");
    AST_CLEAR_RELEASE: assert property (u1_wr && pwdata_in[7:0] == 8'h00 |=> !unit_pin_own_out[0] && !unit_output_pin_out[0])
        else $error("control clear did not release pin");
    AST_SOFT_NO_OWN: assert property (u1_wr && pwdata_in[3:0] == TCEU_MODE_SOFT_IRQ |=> !unit_pin_own_out[0])
        else $error("soft interrupt mode owns pin");
    AST_SOFT_PIN: assert property (mode1_reg == TCEU_MODE_SOFT_IRQ && $past(mode1_reg) == TCEU_MODE_SOFT_IRQ
        |-> $stable(unit_output_pin_out[0]))
        else $error("soft interrupt mode moved pin");
    AST_ENTRY_HIGH: assert property (u1_wr && pwdata_in[3:0] == TCEU_MODE_CLR_ON_MATCH
        && mode1_reg != TCEU_MODE_CLR_ON_MATCH |=> unit_output_pin_out[0])
        else $error("clear on match entry not high");
    AST_CLR_NO_RISE: assert property (mode1_reg == TCEU_MODE_CLR_ON_MATCH && $past(mode1_reg) == TCEU_MODE_CLR_ON_MATCH
        |-> !$rose(unit_output_pin_out[0]))
        else $error("pin rose in clear on match mode");
    cover property (adc_start_out);
    cover property (pslverr_out);
    cover property ($fell(unit_output_pin_out[0]));
endmodule : tceu_props
`default_nettype wire

// file: verif/timer_compare_event_unit_test.sv
// Testbench for the timer compare event unit
`timescale 1ns/1ns
`default_nettype none
module timer_compare_event_unit_test;
    import tceu_pkg::*;
    logic clk_in, rstn_in, psel_in, penable_in, pwrite_in, adc_en;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd_data;
    logic pready_out, pslverr_out, rd_err, timer_a_reset_out, timer_c_reset_out, adc_start_out, adc_enabled_in, irq_out;
    logic [15:0] timer_a_pair_in, timer_c_pair_in;
    logic [9:0] tb_base;
    logic [7:0] timer_c_control_out, conv;
    logic [1:0] unit_output_pin_out, unit_pin_own_out;
    int errors, total_checks, cycles, na, nc, a0, c0, v0;
    tceu_top dut (.clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
        .pready_out, .pslverr_out, .timer_a_pair_in, .timer_c_pair_in, .timer_b_count_in(tb_base[9:2]),
        .timer_b_fine_in(tb_base[1:0]), .pwm_period_reg_in(8'h07), .timer_b_control_in(8'h04), .adc_enabled_in,
        .unit_output_pin_out, .unit_pin_own_out, .timer_a_reset_out, .timer_c_reset_out, .adc_start_out,
        .timer_c_control_out, .irq_out);
    tceu_partner far (.clk_in, .rstn_in, .timer_a_reset_in(timer_a_reset_out), .timer_c_reset_in(timer_c_reset_out),
        .adc_start_in(adc_start_out), .adc_enable_in(adc_en), .timer_a_out(timer_a_pair_in),
        .timer_c_out(timer_c_pair_in), .timer_b_out(tb_base), .adc_enabled_out(adc_enabled_in), .conv_count_out(conv));
    task wrap_up();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1);
        rd_data = prdata_out;
        rd_err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : xfer
    task rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(name, rd_data, exp);
    endtask : rchk
    task wait_pin(input int u, input logic v);
        int n;
        n = 0;
        while (unit_output_pin_out[u] !== v && n < 200)
        begin
            @(posedge clk_in);
            n++;
        end
        chk("pin", unit_output_pin_out[u], v);
    endtask : wait_pin
    initial
    begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end
    // Trigger pulse counters and hang limit
    always @(posedge clk_in)
    begin
        na <= na + int'(timer_a_reset_out === 1'b1);
        nc <= nc + int'(timer_c_reset_out === 1'b1);
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            wrap_up();
        end
    end
    initial
    begin
        {rstn_in, psel_in, penable_in, pwrite_in, adc_en} = 5'h00;
        paddr_in = 8'h00;
        pwdata_in = 32'h0;
        repeat (4) @(posedge clk_in);
        rstn_in <= 1'b1;
        for (int i = 0; i < 9; i++)
            rchk("reset", 8'(i * 4), 32'h0);
        xfer(1'b0, 8'h24, 32'h0);
        chk("slverr", rd_err, 1'b1);
        xfer(1'b1, TCEU_OFF_U2_CTRL, 32'hFF);
        rchk("u2ctrl", TCEU_OFF_U2_CTRL, 32'(TCEU_U2_CTRL_MASK));
        chk("own2", unit_pin_own_out[1], 1'b1);
        xfer(1'b1, TCEU_OFF_U2_CTRL, 32'h00);
        $display("test registers done");
        xfer(1'b1, TCEU_OFF_U1_LOW, 32'h10);
        chk("u2pin", {unit_pin_own_out[1], unit_output_pin_out[1]}, 2'b00);
        xfer(1'b1, TCEU_OFF_U1_CTRL, 32'(TCEU_MODE_SET_ON_MATCH));
        wait_pin(0, 1'b1);
        chk("own", unit_pin_own_out[0], 1'b1);
        rchk("status", TCEU_OFF_IRQ_STAT, 32'h1);
        xfer(1'b1, TCEU_OFF_IRQ_MASK, 32'h1);
        repeat (2) @(posedge clk_in);
        chk("irq", irq_out, 1'b1);
        xfer(1'b1, TCEU_OFF_IRQ_STAT, 32'h1);
        repeat (2) @(posedge clk_in);
        chk("irq", irq_out, 1'b0);
        xfer(1'b1, TCEU_OFF_U1_CTRL, 32'h00);
        @(posedge clk_in);
        chk("pin", {unit_pin_own_out[0], unit_output_pin_out[0]}, 2'b00);
        xfer(1'b1, TCEU_OFF_U1_CTRL, 32'(TCEU_MODE_CLR_ON_MATCH));
        @(posedge clk_in);
        chk("pin", unit_output_pin_out[0], 1'b1);
        wait_pin(0, 1'b0);
        xfer(1'b1, TCEU_OFF_U1_CTRL, 32'(TCEU_MODE_TOGGLE));
        wait_pin(0, 1'b1);
        wait_pin(0, 1'b0);
        $display("test pin actions done");
        xfer(1'b1, TCEU_OFF_U1_CTRL, 32'(TCEU_MODE_SOFT_IRQ));
        xfer(1'b1, TCEU_OFF_IRQ_STAT, 32'h3);
        repeat (70) @(posedge clk_in);
        rchk("status", TCEU_OFF_IRQ_STAT, 32'h1);
        chk("own", unit_pin_own_out[0], 1'b0);
        a0 = na;
        c0 = nc;
        xfer(1'b1, TCEU_OFF_U1_CTRL, 32'(TCEU_MODE_SPECIAL));
        repeat (140) @(posedge clk_in);
        chk("ta_reset", 32'(na > a0), 32'h1);
        chk("tc_reset", 32'(nc - c0), 32'h0);
        xfer(1'b1, TCEU_OFF_U1_CTRL, 32'h00);
        xfer(1'b1, TCEU_OFF_TC_CTRL, 32'h08);
        rchk("tcctrl", TCEU_OFF_TC_CTRL, 32'h08);
        chk("tcout", timer_c_control_out, 8'h08);
        xfer(1'b1, TCEU_OFF_U2_LOW, 32'h10);
        adc_en <= 1'b1;
        xfer(1'b1, TCEU_OFF_IRQ_STAT, 32'h3);
        xfer(1'b1, TCEU_OFF_U2_CTRL, 32'(TCEU_MODE_SPECIAL));
        a0 = na;
        c0 = nc;
        v0 = conv;
        repeat (140) @(posedge clk_in);
        chk("tc_reset", 32'(nc > c0), 32'h1);
        chk("ta_reset", 32'(na - a0), 32'h0);
        chk("conv", 32'(conv - 8'(v0)), 32'(nc - c0));
        rchk("status", TCEU_OFF_IRQ_STAT, 32'h2);
        adc_en <= 1'b0;
        repeat (4) @(posedge clk_in);
        v0 = conv;
        repeat (140) @(posedge clk_in);
        chk("conv", 32'(conv - 8'(v0)), 32'h0);
        $display("test special event done");
        xfer(1'b1, TCEU_OFF_U1_LOW, 32'h02);
        xfer(1'b1, TCEU_OFF_U1_CTRL, 32'h0C);
        @(posedge clk_in);
        chk("own", unit_pin_own_out[0], 1'b1);
        wait_pin(0, 1'b1);
        wait_pin(0, 1'b0);
        rchk("duty", TCEU_OFF_U1_HIGH, 32'h02);
        $display("test pwm entry done");
        wrap_up();
    end
endmodule : timer_compare_event_unit_test
bind tceu_top tceu_props props_i (.clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
    .prdata_out, .pready_out, .pslverr_out, .adc_enabled_in, .unit_output_pin_out, .unit_pin_own_out,
    .timer_a_reset_out, .timer_c_reset_out, .adc_start_out);
`default_nettype wire
